/* File: cfp_params.svh */
/*
 Constants shared by both ends of the checksum and framing link.
 Assumes it is included by bare name and that hclk runs the whole design.
*/
`ifndef CFP_PARAMS_SVH
`define CFP_PARAMS_SVH

// Broadside register window of the attached core.
`define CFP_WIN_CONFIG   5'h19
`define CFP_WIN_RESULT   5'h1c
`define CFP_WIN_PUSH     5'h1d

// Checksum polynomials and seeds.
`define CFP_POLY32       32'h04c11db7
`define CFP_POLY16       32'h00008005
`define CFP_POLYCC       32'h00001021
`define CFP_SEED32       32'hffffffff
`define CFP_SEED16       32'h00000000
`define CFP_SEEDCC       32'h0000ffff

// Framing.
`define CFP_START_WORD   16'h8000
`define CFP_START_SKIP   4'hf
`define CFP_PREAMBLE     16'h55d5
`define CFP_FRAME_BYTES  4'h8
`define CFP_WORD_BITS    5'h10
`define CFP_SYM_BITS     5'h0a
`define CFP_RX_GROUP     5'h14
`define CFP_RX_GROUPS    3'h4

// Controller registers on the AHB-Lite side.
`define CFP_REG_CTRL     8'h00
`define CFP_REG_TXDATA   8'h04
`define CFP_REG_STATUS   8'h08
`define CFP_REG_RXDATA   8'h0c
`define CFP_CTRL_RST     2'h1
`define CFP_ST_BUSY      0
`define CFP_ST_RXFULL    1
`define CFP_ST_CRCERR    2
`define CFP_ST_CODEERR   3
`define CFP_ST_PREERR    4

`endif

/* File: cfp_pkg.sv */
/*
 Types shared by both ends of the checksum and framing link.
 Assumes nothing beyond a SystemVerilog tool.
*/
package cfp_pkg;
    typedef enum logic [1:0] {CFP_CRC32, CFP_CRC16, CFP_CCITT} cfp_crc_e;
    typedef enum logic [1:0] {CFP_SZ8, CFP_SZ16, CFP_SZ32} cfp_size_e;
    typedef enum logic [1:0] {CFP_RX_IDLE, CFP_RX_SKIP, CFP_RX_DATA} cfp_rx_e;
    typedef enum logic [2:0] {CFP_CO_IDLE, CFP_CO_HI, CFP_CO_LO, CFP_CO_WAIT, CFP_CO_READ, CFP_CO_SEND} cfp_core_e;
endpackage : cfp_pkg

/* File: cfp_link_if.sv */
/*
 Broadside window and frame hand-off between the attached core and the device.
 Assumes both ends run on the same hclk.
*/
`timescale 1ns/1ps
interface cfp_link_if;
    logic                    bs_we;
    logic [4:0]              bs_idx;
    logic [31:0]             bs_wdata;
    cfp_pkg::cfp_size_e      bs_size;
    logic [31:0]             result;
    logic                    tx_valid;
    logic [63:0]             tx_frame;
    logic                    tx_ready;
    logic                    rx_valid;
    logic [63:0]             rx_frame;
    logic                    rx_code_err;

    modport dev (input bs_we, bs_idx, bs_wdata, bs_size, tx_valid, tx_frame,
                 output result, tx_ready, rx_valid, rx_frame, rx_code_err);
    modport core (output bs_we, bs_idx, bs_wdata, bs_size, tx_valid, tx_frame,
                  input result, tx_ready, rx_valid, rx_frame, rx_code_err);
endinterface : cfp_link_if

/* File: cfp_dev_end.sv */
/*
 Device end: checksum engine on the broadside window, line-code packer,
 serial transmitter and receiver. Assumes the serial inputs are synchronous
 to hclk and the far transmitter uses the same start word and framing.
*/
// Our own choices: the register addresses and the AHB-Lite register port.
// Operation
// - Three polynomials: CRC32, CRC16, CCITT.
// - Push up to 32 bits; 16/32 result.
// - Config at window 25, push at 29.
// - Running result readable at window 28.
// - Feeder byte-swaps each word before pushing.
// - Sender places 16-bit checksum in frame.
// - Pack 10-bit symbols contiguously into 16-bit words.
// - Eight byte encodings give 80 bits.
// - Eight decodings recover 64 bits.
// - Frame: preamble, 32 data bits, checksum.
// - Start shifting after 16 bits encoded.
// - Decode once 20 encoded bits arrive.
// - Send start word; receiver skips start word.
// - Shift clock is core clock halved.
`timescale 1ns/1ps
`include "cfp_params.svh"
module cfp_dev_end (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Core side
    cfp_link_if.dev   lnk,
    // Serial link
    output logic      tx_sclk,
    output logic      tx_sdata,
    input  wire logic rx_sclk,
    input  wire logic rx_sdata
);
    // Running-disparity-negative forms; the positive forms are complements for unbalanced forms, six-bit entry 7 and four-bit entry 3.
    localparam logic [5:0] T6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
                                       6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
                                       6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
                                       6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] T4 [8]  = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

    cfp_pkg::cfp_crc_e type_q;
    cfp_pkg::cfp_crc_e new_type;
    logic [31:0]       crc_next;
    logic              sclk_q;
    logic              run_q;
    logic [63:0]       frame_q;
    logic [3:0]        byte_cnt_q;
    logic              rd_q;
    logic [31:0]       pack_q;
    logic [4:0]        pack_cnt_q;
    logic [15:0]       sh_q;
    logic [4:0]        sh_cnt_q;
    logic [10:0]       enc_out;
    logic              enc_go;
    logic              take;
    logic              accept;
    logic [15:0]       word;
    cfp_pkg::cfp_rx_e  rx_st_q;
    logic              rx_prev_q;
    logic [4:0]        rx_cnt_q;
    logic [2:0]        rx_grp_q;
    logic [18:0]       rx_sr_q;
    logic [47:0]       rx_acc_q;
    logic              rx_err_q;
    logic              rise;
    logic [19:0]       grp;
    logic [8:0]        dec0;
    logic [8:0]        dec1;

    function automatic logic [31:0] seed_of(input cfp_pkg::cfp_crc_e t);
        case (t)
            cfp_pkg::CFP_CRC16: seed_of = `CFP_SEED16;
            cfp_pkg::CFP_CCITT: seed_of = `CFP_SEEDCC;
            default:            seed_of = `CFP_SEED32;
        endcase
    endfunction : seed_of

    // Bytes are taken low byte first, each byte most significant bit first.
    function automatic logic [31:0] crc_step(input logic [31:0] acc, input logic [31:0] d,
                                             input cfp_pkg::cfp_size_e sz, input cfp_pkg::cfp_crc_e t);
        logic [31:0] c;
        logic [31:0] poly;
        logic        fb;
        int          top;
        int          n;
        c    = acc;
        poly = (t == cfp_pkg::CFP_CRC32) ? `CFP_POLY32 : (t == cfp_pkg::CFP_CRC16) ? `CFP_POLY16 : `CFP_POLYCC;
        top  = (t == cfp_pkg::CFP_CRC32) ? 31 : 15;
        n    = (sz == cfp_pkg::CFP_SZ8) ? 1 : (sz == cfp_pkg::CFP_SZ16) ? 2 : 4;
        for (int i = 0; i < 4; i++) begin
            for (int b = 7; b >= 0; b--) begin
                if (i < n) begin
                    fb = c[top] ^ d[8*i+b];
                    c  = {c[30:0], 1'b0} ^ (fb ? poly : 32'h0);
                end
            end
        end
        crc_step = (t == cfp_pkg::CFP_CRC32) ? c : (c & 32'h0000ffff);
    endfunction : crc_step

    // Returns the new disparity over the ten symbol bits, first bit at the top.
    function automatic logic [10:0] enc8(input logic [7:0] b, input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic       r;
        s6 = T6[b[4:0]];
        if (rd && ($countones(s6) != 3 || b[4:0] == 5'h07))
            s6 = ~s6;
        r  = ($countones(s6) != 3) ? ~rd : rd;
        s4 = T4[b[7:5]];
        if (r && ($countones(s4) != 2 || b[7:5] == 3'h3))
            s4 = ~s4;
        r  = ($countones(s4) != 2) ? ~r : r;
        enc8 = {r, s6, s4};
    endfunction : enc8

    // Returns the code error flag above the recovered byte.
    function automatic logic [8:0] dec10(input logic [9:0] s);
        logic [7:0] v;
        logic       h6;
        logic       h4;
        v  = 8'h00;
        h6 = 1'b0;
        h4 = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (s[9:4] == T6[i] || (s[9:4] == ~T6[i] && ($countones(T6[i]) != 3 || i == 7))) begin
                v[4:0] = 5'(i);
                h6     = 1'b1;
            end
        end
        for (int j = 0; j < 8; j++) begin
            if (s[3:0] == T4[j] || (s[3:0] == ~T4[j] && ($countones(T4[j]) != 2 || j == 3))) begin
                v[7:5] = 3'(j);
                h4     = 1'b1;
            end
        end
        dec10 = {~(h6 & h4), v};
    endfunction : dec10

    assign new_type = cfp_pkg::cfp_crc_e'(lnk.bs_wdata[1:0]);
    assign crc_next = crc_step(lnk.result, lnk.bs_wdata, lnk.bs_size, type_q);

    // Checksum engine; the result register is the running accumulator.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            type_q     <= cfp_pkg::CFP_CRC32;
            lnk.result <= `CFP_SEED32;
        end else if (lnk.bs_we && lnk.bs_idx == `CFP_WIN_CONFIG) begin
            type_q     <= new_type;
            lnk.result <= seed_of(new_type);
        end else if (lnk.bs_we && lnk.bs_idx == `CFP_WIN_PUSH) begin
            lnk.result <= crc_next;
        end
    end

    // Free-running shift clock at half of hclk.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_q  <= 1'b0;
            tx_sclk <= 1'b0;
        end else begin
            sclk_q  <= ~sclk_q;
            tx_sclk <= ~sclk_q;
        end
    end

    assign accept  = lnk.tx_valid && lnk.tx_ready;
    assign enc_out = enc8(frame_q[63:56], rd_q);
    assign enc_go  = run_q && byte_cnt_q != `CFP_FRAME_BYTES && pack_cnt_q <= 5'h0f;
    assign word    = 16'(pack_q >> (pack_cnt_q - `CFP_WORD_BITS));
    // Reloading on the last bit keeps the line continuous between words.
    assign take    = run_q && pack_cnt_q >= `CFP_WORD_BITS && (sh_cnt_q == 5'h00 || (sclk_q && sh_cnt_q == 5'h01));

    // Frame intake and byte encoder feeding the packer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q        <= 1'b0;
            lnk.tx_ready <= 1'b1;
            frame_q      <= 64'h0;
            byte_cnt_q   <= 4'h0;
            rd_q         <= 1'b0;
        end else if (accept) begin
            run_q        <= 1'b1;
            lnk.tx_ready <= 1'b0;
            frame_q      <= lnk.tx_frame;
            byte_cnt_q   <= 4'h0;
        end else if (enc_go) begin
            frame_q      <= {frame_q[55:0], 8'h00};
            byte_cnt_q   <= byte_cnt_q + 4'h1;
            rd_q         <= enc_out[10];
        end else if (run_q && byte_cnt_q == `CFP_FRAME_BYTES && pack_cnt_q == 5'h00 && sh_cnt_q == 5'h00) begin
            run_q        <= 1'b0;
            lnk.tx_ready <= 1'b1;
        end
    end

    // Packer: ten-bit symbols appended with no gaps, oldest bits on top.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pack_q     <= 32'h0;
            pack_cnt_q <= 5'h00;
        end else begin
            if (enc_go)
                pack_q <= {pack_q[21:0], enc_out[9:0]};
            pack_cnt_q <= pack_cnt_q - (take ? `CFP_WORD_BITS : 5'h00) + (enc_go ? `CFP_SYM_BITS : 5'h00);
        end
    end

    // Shifter: start word first, then packed words once 16 bits exist and the shifter is empty or on its last bit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_q     <= 16'h0;
            sh_cnt_q <= 5'h00;
            tx_sdata <= 1'b0;
        end else begin
            if (sclk_q)
                tx_sdata <= (sh_cnt_q != 5'h00) ? sh_q[15] : 1'b0;
            if (accept && !run_q) begin
                sh_q     <= `CFP_START_WORD;
                sh_cnt_q <= `CFP_WORD_BITS;
            end else if (take) begin
                sh_q     <= word;
                sh_cnt_q <= `CFP_WORD_BITS;
            end else if (sclk_q && sh_cnt_q != 5'h00) begin
                sh_q     <= {sh_q[14:0], 1'b0};
                sh_cnt_q <= sh_cnt_q - 5'h01;
            end
        end
    end

    assign rise = rx_sclk && !rx_prev_q;
    assign grp  = {rx_sr_q, rx_sdata};
    assign dec0 = dec10(grp[19:10]);
    assign dec1 = dec10(grp[9:0]);

    // Receiver: start bit and the rest of the start word, then 20-bit groups.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_prev_q       <= 1'b0;
            rx_st_q         <= cfp_pkg::CFP_RX_IDLE;
            rx_cnt_q        <= 5'h00;
            rx_grp_q        <= 3'h0;
            rx_sr_q         <= 19'h0;
            rx_acc_q        <= 48'h0;
            rx_err_q        <= 1'b0;
            lnk.rx_valid    <= 1'b0;
            lnk.rx_frame    <= 64'h0;
            lnk.rx_code_err <= 1'b0;
        end else begin
            rx_prev_q    <= rx_sclk;
            lnk.rx_valid <= 1'b0;
            if (rise) begin
                case (rx_st_q)
                    cfp_pkg::CFP_RX_IDLE: begin
                        if (rx_sdata) begin
                            rx_st_q  <= cfp_pkg::CFP_RX_SKIP;
                            rx_cnt_q <= 5'h00;
                        end
                    end
                    cfp_pkg::CFP_RX_SKIP: begin
                        rx_cnt_q <= rx_cnt_q + 5'h01;
                        if (rx_cnt_q == {1'b0, `CFP_START_SKIP} - 5'h01) begin
                            rx_st_q  <= cfp_pkg::CFP_RX_DATA;
                            rx_cnt_q <= 5'h00;
                            rx_grp_q <= 3'h0;
                            rx_err_q <= 1'b0;
                        end
                    end
                    cfp_pkg::CFP_RX_DATA: begin
                        rx_sr_q <= grp[18:0];
                        if (rx_cnt_q == `CFP_RX_GROUP - 5'h01) begin
                            rx_cnt_q <= 5'h00;
                            rx_grp_q <= rx_grp_q + 3'h1;
                            rx_acc_q <= {rx_acc_q[31:0], dec0[7:0], dec1[7:0]};
                            rx_err_q <= rx_err_q | dec0[8] | dec1[8];
                            if (rx_grp_q == `CFP_RX_GROUPS - 3'h1) begin
                                lnk.rx_valid    <= 1'b1;
                                lnk.rx_frame    <= {rx_acc_q, dec0[7:0], dec1[7:0]};
                                lnk.rx_code_err <= rx_err_q | dec0[8] | dec1[8];
                                rx_st_q         <= cfp_pkg::CFP_RX_IDLE;
                            end
                        end else begin
                            rx_cnt_q <= rx_cnt_q + 5'h01;
                        end
                    end
                    default: rx_st_q <= cfp_pkg::CFP_RX_IDLE;
                endcase
            end
        end
    end
endmodule : cfp_dev_end

/* File: cfp_core_end.sv */
/*
 Core end: AHB-Lite controller that checksums payloads on the device engine,
 hands framed data to the transmitter and checks received frames.
 Assumes a single AHB-Lite master and the device answering as described.
*/
`timescale 1ns/1ps
`include "cfp_params.svh"
module cfp_core_end (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic        hwrite,
    input  wire logic [1:0]  htrans,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Device side
    cfp_link_if.core         lnk
);
    cfp_pkg::cfp_core_e st_q;
    logic               acc;
    logic               wr_q;
    logic [7:0]         waddr_q;
    logic [1:0]         type_q;
    logic [31:0]        payload_q;
    logic               tx_pend_q;
    logic               rx_pend_q;
    logic [63:0]        rx_hold_q;
    logic               rx_code_q;
    logic               job_rx_q;
    logic [31:0]        word_q;
    logic [31:0]        rx_data_q;
    logic               rx_full_q;
    logic               crc_err_q;
    logic               pre_err_q;
    logic               code_err_q;
    logic               start_rx;
    logic               start_tx;
    logic               rx_done;
    logic [31:0]        status;

    function automatic logic [31:0] swap16(input logic [15:0] w);
        swap16 = {16'h0, w[7:0], w[15:8]};
    endfunction : swap16

    assign acc      = hsel && htrans[1] && hready;
    assign start_rx = st_q == cfp_pkg::CFP_CO_IDLE && rx_pend_q;
    assign start_tx = st_q == cfp_pkg::CFP_CO_IDLE && !rx_pend_q && tx_pend_q;
    assign rx_done  = st_q == cfp_pkg::CFP_CO_READ && job_rx_q;
    assign status   = {27'h0, pre_err_q, code_err_q, crc_err_q, rx_full_q, tx_pend_q || st_q != cfp_pkg::CFP_CO_IDLE};

    // Address phase capture and registered read data; never waits.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q      <= 1'b0;
            waddr_q   <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_q      <= acc && hwrite && hsize == 3'h2;
            waddr_q   <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (acc && !hwrite) begin
                case (haddr[7:0])
                    `CFP_REG_CTRL:   hrdata <= {30'h0, type_q};
                    `CFP_REG_TXDATA: hrdata <= payload_q;
                    `CFP_REG_STATUS: hrdata <= status;
                    `CFP_REG_RXDATA: hrdata <= rx_data_q;
                    default:         hrdata <= 32'h0;
                endcase
            end
        end
    end

    // Register writes; a new payload queues a send, a payload write wins over a start in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            type_q    <= `CFP_CTRL_RST;
            payload_q <= 32'h0;
            tx_pend_q <= 1'b0;
        end else begin
            if (start_tx)
                tx_pend_q <= 1'b0;
            if (wr_q && waddr_q == `CFP_REG_CTRL)
                type_q <= hwdata[1:0];
            if (wr_q && waddr_q == `CFP_REG_TXDATA) begin
                payload_q <= hwdata;
                tx_pend_q <= 1'b1;
            end
        end
    end

    // Received frames wait here for their checksum check.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_pend_q <= 1'b0;
            rx_hold_q <= 64'h0;
            rx_code_q <= 1'b0;
        end else if (lnk.rx_valid) begin
            rx_pend_q <= 1'b1;
            rx_hold_q <= lnk.rx_frame;
            rx_code_q <= lnk.rx_code_err;
        end else if (start_rx) begin
            rx_pend_q <= 1'b0;
        end
    end

    // Reading the receive data frees the slot; a new frame in the same cycle wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            rx_full_q <= 1'b0;
        else if (rx_done)
            rx_full_q <= 1'b1;
        else if (acc && !hwrite && haddr[7:0] == `CFP_REG_RXDATA)
            rx_full_q <= 1'b0;
    end

    // Sequencer: reseed, push two swapped halves, read result, then send or check.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q         <= cfp_pkg::CFP_CO_IDLE;
            job_rx_q     <= 1'b0;
            word_q       <= 32'h0;
            lnk.bs_we    <= 1'b0;
            lnk.bs_idx   <= `CFP_WIN_CONFIG;
            lnk.bs_wdata <= 32'h0;
            lnk.bs_size  <= cfp_pkg::CFP_SZ16;
            lnk.tx_valid <= 1'b0;
            lnk.tx_frame <= 64'h0;
            rx_data_q    <= 32'h0;
            crc_err_q    <= 1'b0;
            pre_err_q    <= 1'b0;
            code_err_q   <= 1'b0;
        end else begin
            lnk.bs_we <= 1'b0;
            case (st_q)
                cfp_pkg::CFP_CO_IDLE: begin
                    if (start_rx || start_tx) begin
                        job_rx_q     <= start_rx;
                        word_q       <= start_rx ? rx_hold_q[47:16] : payload_q;
                        lnk.bs_we    <= 1'b1;
                        lnk.bs_idx   <= `CFP_WIN_CONFIG;
                        lnk.bs_wdata <= {30'h0, type_q};
                        st_q         <= cfp_pkg::CFP_CO_HI;
                    end
                end
                cfp_pkg::CFP_CO_HI: begin
                    lnk.bs_we    <= 1'b1;
                    lnk.bs_idx   <= `CFP_WIN_PUSH;
                    lnk.bs_size  <= cfp_pkg::CFP_SZ16;
                    lnk.bs_wdata <= swap16(word_q[31:16]);
                    st_q         <= cfp_pkg::CFP_CO_LO;
                end
                cfp_pkg::CFP_CO_LO: begin
                    lnk.bs_we    <= 1'b1;
                    lnk.bs_wdata <= swap16(word_q[15:0]);
                    st_q         <= cfp_pkg::CFP_CO_WAIT;
                end
                cfp_pkg::CFP_CO_WAIT: st_q <= cfp_pkg::CFP_CO_READ;
                cfp_pkg::CFP_CO_READ: begin
                    if (job_rx_q) begin
                        rx_data_q  <= word_q;
                        crc_err_q  <= lnk.result[15:0] != rx_hold_q[15:0];
                        pre_err_q  <= rx_hold_q[63:48] != `CFP_PREAMBLE;
                        code_err_q <= rx_code_q;
                        st_q       <= cfp_pkg::CFP_CO_IDLE;
                    end else begin
                        lnk.tx_frame <= {`CFP_PREAMBLE, word_q, lnk.result[15:0]};
                        lnk.tx_valid <= 1'b1;
                        st_q         <= cfp_pkg::CFP_CO_SEND;
                    end
                end
                cfp_pkg::CFP_CO_SEND: begin
                    if (lnk.tx_ready) begin
                        lnk.tx_valid <= 1'b0;
                        st_q         <= cfp_pkg::CFP_CO_IDLE;
                    end
                end
                default: st_q <= cfp_pkg::CFP_CO_IDLE;
            endcase
        end
    end
endmodule : cfp_core_end

/* File: cfp_link_monitor.sv */
/*
 Concurrent checks on the link between the core end and the device end.
 Assumes one hclk domain and the serial lines looped back by the bench.
*/
`timescale 1ns/1ps
`include "cfp_params.svh"
module cfp_link_monitor (
    // Clock and reset
    input logic               hclk,
    input logic               hresetn,
    // Link signals
    input logic               bs_we,
    input logic [4:0]         bs_idx,
    input logic [31:0]        bs_wdata,
    input cfp_pkg::cfp_size_e bs_size,
    input logic [31:0]        result,
    input logic               tx_valid,
    input logic [63:0]        tx_frame,
    input logic               tx_ready,
    input logic               rx_valid,
    input logic [63:0]        rx_frame,
    input logic               rx_code_err
);
    wire logic cfg = bs_we && bs_idx == `CFP_WIN_CONFIG;
    wire logic hs  = tx_valid && tx_ready;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_SEED32: assert property (cfg && bs_wdata[1:0] == 2'h0 |=> result == `CFP_SEED32) else $error("seed32");
    AST_SEED16: assert property (cfg && bs_wdata[1:0] == 2'h1 |=> result == `CFP_SEED16) else $error("seed16");
    AST_SEEDCC: assert property (cfg && bs_wdata[1:0] == 2'h2 |=> result == `CFP_SEEDCC) else $error("seedcc");
    AST_HOLD: assert property (!bs_we |=> $stable(result)) else $error("result moved without a write");
    AST_PRE: assert property (tx_valid |-> tx_frame[63:48] == `CFP_PREAMBLE) else $error("bad preamble");
    AST_BUSY: assert property (hs |-> ##170 !tx_ready) else $error("frame ended too soon");
    AST_DONE: assert property (hs |-> ##[180:300] tx_ready) else $error("frame never ended");
    AST_RXLAT: assert property (hs |-> ##[180:320] rx_valid) else $error("frame not received");
    AST_RXPULSE: assert property (rx_valid |=> !rx_valid) else $error("rx pulse too long");
    AST_CODE: assert property (rx_valid |-> !rx_code_err) else $error("symbol error");
    AST_SIZE: assert property (bs_we && bs_idx == `CFP_WIN_PUSH |-> bs_size == cfp_pkg::CFP_SZ16) else $error("push not 16 bits");
    AST_SWAP: assert property ($rose(tx_valid) |-> $past(bs_wdata, 3) == {16'h0, tx_frame[39:32], tx_frame[47:40]} && bs_wdata == {16'h0, tx_frame[23:16], tx_frame[31:24]}) else $error("push not byte swapped");
    AST_RXPRE: assert property (rx_valid |-> rx_frame[63:48] == `CFP_PREAMBLE) else $error("bad received preamble");
    COV_CFG: cover property (cfg);
    COV_PUSH: cover property (bs_we && bs_idx == `CFP_WIN_PUSH);
    COV_RX: cover property (rx_valid);
endmodule : cfp_link_monitor

/* File: crc_frame_packer_tb.sv */
/*
 Self-checking bench: AHB-Lite master on the core end, device serial output looped to its input.
 Assumes both ends, the link interface and the monitor are compiled first.
*/
`timescale 1ns/1ps
module crc_frame_packer_tb;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, tx_sclk, tx_sdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          n_mismatch = 0, check_count = 0;
    cfp_link_if lnk ();
    assign hready = hreadyout;
    cfp_core_end i_cfp_core_end (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .hwrite(hwrite),
        .htrans(htrans), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .lnk(lnk.core));
    // Loopback lets one device check its own framing end to end.
    cfp_dev_end i_cfp_dev_end (.hclk(hclk), .hresetn(hresetn), .lnk(lnk.dev), .tx_sclk(tx_sclk),
        .tx_sdata(tx_sdata), .rx_sclk(tx_sclk), .rx_sdata(tx_sdata));
    cfp_link_monitor i_cfp_link_monitor (.hclk(hclk), .hresetn(hresetn), .bs_we(lnk.bs_we), .bs_idx(lnk.bs_idx),
        .bs_wdata(lnk.bs_wdata), .bs_size(lnk.bs_size), .result(lnk.result), .tx_valid(lnk.tx_valid),
        .tx_frame(lnk.tx_frame), .tx_ready(lnk.tx_ready), .rx_valid(lnk.rx_valid), .rx_frame(lnk.rx_frame),
        .rx_code_err(lnk.rx_code_err));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task s_regs;
        ahb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h1);
        chk({31'h0, hresp}, 32'h0);
        ahb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
    endtask : s_regs
    task s_clock;
        time t0;
        @(posedge tx_sclk);
        t0 = $time;
        @(posedge tx_sclk);
        chk(32'($time - t0), 32'h32);
    endtask : s_clock
    task s_frame(input logic [1:0] t, input logic [31:0] p);
        int n;
        chk({31'h0, tx_sdata}, 32'h0);
        ahb(1'b1, 8'h00, {30'h0, t});
        ahb(1'b0, 8'h00, 32'h0);
        chk(rd, {30'h0, t});
        ahb(1'b1, 8'h04, p);
        ahb(1'b0, 8'h08, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
        ahb(1'b0, 8'h04, 32'h0);
        chk(rd, p);
        n = 0;
        do begin
            ahb(1'b0, 8'h08, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 200);
        chk({28'h0, rd[4:1]}, 32'h1);
        ahb(1'b0, 8'h0c, 32'h0);
        chk(rd, p);
        ahb(1'b0, 8'h08, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h0);
    endtask : s_frame
    task complete_run;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        s_regs;
        s_clock;
        s_frame(2'h0, 32'hffffffff);
        s_frame(2'h1, 32'h12345678);
        s_frame(2'h2, 32'h00000000);
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        complete_run;
    end
endmodule : crc_frame_packer_tb
